// >>> src/eeslv_regs.vh
// constants for the two-wire serial memory slave
`ifndef EESLV_REGS_VH
`define EESLV_REGS_VH

// device-type code, value is arbitrary
`define EESLV_DEV_TYPE    4'h6

// slave address byte fields
`define EESLV_SA_TYPE_HI  7
`define EESLV_SA_TYPE_LO  4
`define EESLV_SA_RW       0

// bits per byte on the wire
`define EESLV_BYTE_BITS   4'h8

// received byte kinds
`define EESLV_K_DEV       2'h0
`define EESLV_K_WADDR     2'h1
`define EESLV_K_DATA      2'h2

// memory geometry
`define EESLV_ADDR_W      8
`define EESLV_DATA_W      8
`define EESLV_PAGE_W      2

// internal programming time
`define EESLV_TWR_US      5000
`define EESLV_CLK_KHZ     25000
`define EESLV_TWR_CYCLES  ((`EESLV_TWR_US * `EESLV_CLK_KHZ) / 1000)
`define EESLV_TWR_CNT_W   17

`endif

// >>> src/eeslv_sync.v
// two-flop synchroniser for one line from outside the clock domain
`default_nettype none

module eeslv_sync
(
    // clock and reset
    input  wire core_clk,
    input  wire reset_n,
    // asynchronous line and its synchronised copy
    input  wire line_i,
    output wire line_s
);

    reg meta_q;
    reg sync_q;

    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end
        else
        begin
            meta_q <= line_i;
            sync_q <= meta_q;
        end
    end

    assign line_s = sync_q;

endmodule // eeslv_sync

`default_nettype wire

// >>> src/eeslv_mem.v
// memory array with registered read data
`default_nettype none

module eeslv_mem
#(
    parameter AW = 8,
    parameter DW = 8
)
(
    // clock
    input  wire          core_clk,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    // read port
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data_q
);

    reg [DW-1:0] mem_q [0:(1<<AW)-1];

    always @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data_q <= mem_q[rd_addr];
    end

endmodule // eeslv_mem

`default_nettype wire

// >>> src/eeslv_top.v
// two-wire slave interface of a 256 x 8 serial memory
`include "eeslv_regs.vh"
`default_nettype none

// Behaviour
// - data changes only while clock low
// - start is data fall, clock high
// - stop is data rise, clock high
// - stop after read enters standby
// - receiver pulls data low on ninth clock
// - acknowledge address match and written bytes
// - read: eight bits, sample ack, continue
// - upper four address bits must match type
// - next three address bits are reserved
// - lowest address bit selects read or write
// - write takes word address then data
// - stop after write starts programming
// - programming ignores every master request
// - page write takes up to four bytes
// - write: only two low address bits increment
// - extra page bytes wrap and overwrite
// - busy withholds ack, idle acknowledges
// - programming lasts about five milliseconds
// - data line driven low or released
// - address counter holds last location plus one
module eeslv_top
#(
    parameter                     DEV_TYPE     = `EESLV_DEV_TYPE,
    parameter                     WRITE_CYCLES = `EESLV_TWR_CYCLES
)
(
    // clock and reset
    input  wire core_clk,
    input  wire reset_n,
    // serial clock from the master
    input  wire scl_i,
    // serial data, open drain
    input  wire sda_i,
    output reg  sda_o_q,
    output reg  sda_oe_q,
    // status
    output reg  busy_q,
    output reg  standby_q
);

    localparam AW    = `EESLV_ADDR_W;
    localparam DW    = `EESLV_DATA_W;
    localparam PW    = `EESLV_PAGE_W;
    localparam CNT_W = `EESLV_TWR_CNT_W;
    localparam NPAGE = 1 << PW;

    localparam [CNT_W-1:0] WR_LAST  = WRITE_CYCLES - 1;
    localparam [3:0]       FULL     = `EESLV_BYTE_BITS;
    localparam [3:0]       DEV_CODE = DEV_TYPE;

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RX   = 3'h1;
    localparam [2:0] ST_ACK  = 3'h2;
    localparam [2:0] ST_TX   = 3'h3;
    localparam [2:0] ST_RACK = 3'h4;

    // ------------------------------------------------------------
    // line sampling and edge detection
    // ------------------------------------------------------------
    wire scl_s;
    wire sda_s;
    reg  scl_p_q;
    reg  sda_p_q;

    eeslv_sync u_scl_sync
    (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .line_i   (scl_i),
        .line_s   (scl_s)
    );

    eeslv_sync u_sda_sync
    (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .line_i   (sda_i),
        .line_s   (sda_s)
    );

    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    // data edges only count while clock stays high
    wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ------------------------------------------------------------
    // protocol state
    // ------------------------------------------------------------
    reg [2:0]       state_q;
    reg [1:0]       kind_q;
    reg [3:0]       bit_cnt_q;
    reg [7:0]       shift_q;
    reg [DW-1:0]    tx_q;
    reg             rw_q;
    reg             mack_q;
    reg [AW-1:0]    addr_q;
    reg [AW-PW-1:0] page_q;
    reg             store_q;
    reg [PW-1:0]    store_idx_q;
    reg [PW-1:0]    commit_idx_q;
    reg             commit_done_q;
    reg [CNT_W-1:0] wait_q;

    wire [DW-1:0]   rd_data;

    // ------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------
    reg  [DW-1:0]   buf_q [0:NPAGE-1];
    reg  [NPAGE-1:0] valid_q;
    wire            buf_clr = busy_q & commit_done_q;

    genvar gi;
    generate
        for (gi = 0; gi < NPAGE; gi = gi + 1)
        begin : g_page
            always @(posedge core_clk)
            begin
                if (!reset_n)
                begin
                    buf_q[gi]   <= {DW{1'b0}};
                    valid_q[gi] <= 1'b0;
                end
                else if (buf_clr)
                begin
                    valid_q[gi] <= 1'b0;
                end
                // later bytes overwrite earlier ones at the same slot
                else if (store_q && store_idx_q == gi)
                begin
                    buf_q[gi]   <= shift_q;
                    valid_q[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // memory array
    // ------------------------------------------------------------
    wire mem_we = busy_q & ~commit_done_q & valid_q[commit_idx_q];

    eeslv_mem
    #(
        .AW (AW),
        .DW (DW)
    )
    u_mem
    (
        .core_clk  (core_clk),
        .wr_en     (mem_we),
        .wr_addr   ({page_q, commit_idx_q}),
        .wr_data   (buf_q[commit_idx_q]),
        .rd_addr   (addr_q),
        .rd_data_q (rd_data)
    );

    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            scl_p_q       <= 1'b1;
            sda_p_q       <= 1'b1;
            state_q       <= ST_IDLE;
            kind_q        <= `EESLV_K_DEV;
            bit_cnt_q     <= 4'h0;
            shift_q       <= 8'h00;
            tx_q          <= {DW{1'b0}};
            rw_q          <= 1'b0;
            mack_q        <= 1'b0;
            addr_q        <= {AW{1'b0}};
            page_q        <= {(AW-PW){1'b0}};
            store_q       <= 1'b0;
            store_idx_q   <= {PW{1'b0}};
            commit_idx_q  <= {PW{1'b0}};
            commit_done_q <= 1'b1;
            wait_q        <= {CNT_W{1'b0}};
            sda_o_q       <= 1'b0;
            sda_oe_q      <= 1'b0;
            busy_q        <= 1'b0;
            standby_q     <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            store_q <= 1'b0;
            // only ever drives low; release is the high level
            sda_o_q <= 1'b0;

            // self-timed programming: commit page then wait
            if (busy_q)
            begin
                if (!commit_done_q)
                begin
                    commit_idx_q <= commit_idx_q + {{(PW-1){1'b0}}, 1'b1};
                    if (&commit_idx_q)
                    begin
                        commit_done_q <= 1'b1;
                    end
                end
                else if (wait_q == WR_LAST)
                begin
                    busy_q <= 1'b0;
                end
                else
                begin
                    wait_q <= wait_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end

            if (busy_q)
            begin
                // inputs disabled: no start, no ack
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end
            else if (stop_ev)
            begin
                state_q   <= ST_IDLE;
                sda_oe_q  <= 1'b0;
                standby_q <= 1'b1;
                if (|valid_q)
                begin
                    busy_q        <= 1'b1;
                    commit_idx_q  <= {PW{1'b0}};
                    commit_done_q <= 1'b0;
                    wait_q        <= {CNT_W{1'b0}};
                end
            end
            else if (start_ev)
            begin
                state_q   <= ST_RX;
                kind_q    <= `EESLV_K_DEV;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        sda_oe_q <= 1'b0;
                    end
                    ST_RX:
                    begin
                        if (scl_rise && bit_cnt_q != FULL)
                        begin
                            shift_q   <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_q == FULL)
                        begin
                            case (kind_q)
                                `EESLV_K_DEV:
                                begin
                                    // reserved bits are not compared
                                    if (shift_q[`EESLV_SA_TYPE_HI:`EESLV_SA_TYPE_LO]
                                        == DEV_CODE)
                                    begin
                                        rw_q      <= shift_q[`EESLV_SA_RW];
                                        sda_oe_q  <= 1'b1;
                                        standby_q <= 1'b0;
                                        state_q   <= ST_ACK;
                                    end
                                    else
                                    begin
                                        state_q <= ST_IDLE;
                                    end
                                end
                                `EESLV_K_WADDR:
                                begin
                                    addr_q   <= shift_q;
                                    sda_oe_q <= 1'b1;
                                    state_q  <= ST_ACK;
                                end
                                default:
                                begin
                                    store_q     <= 1'b1;
                                    store_idx_q <= addr_q[PW-1:0];
                                    page_q      <= addr_q[AW-1:PW];
                                    addr_q      <= {addr_q[AW-1:PW],
                                                    addr_q[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
                                    // high bits held, low bits wrap
                                    sda_oe_q    <= 1'b1;
                                    state_q     <= ST_ACK;
                                end
                            endcase
                        end
                    end
                    ST_ACK:
                    begin
                        // hold low through the ninth clock, change on fall
                        if (scl_fall)
                        begin
                            if (rw_q && kind_q == `EESLV_K_DEV)
                            begin
                                tx_q      <= rd_data;
                                sda_oe_q  <= ~rd_data[DW-1];
                                bit_cnt_q <= 4'h1;
                                addr_q    <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                                state_q   <= ST_TX;
                            end
                            else
                            begin
                                sda_oe_q  <= 1'b0;
                                kind_q    <= (kind_q == `EESLV_K_DEV) ?
                                             `EESLV_K_WADDR : `EESLV_K_DATA;
                                bit_cnt_q <= 4'h0;
                                state_q   <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_q == FULL)
                            begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_RACK;
                            end
                            else
                            begin
                                sda_oe_q  <= ~tx_q[DW-2];
                                tx_q      <= {tx_q[DW-2:0], 1'b0};
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            mack_q <= ~sda_s;
                        end
                        else if (scl_fall)
                        begin
                            if (mack_q)
                            begin
                                tx_q      <= rd_data;
                                sda_oe_q  <= ~rd_data[DW-1];
                                bit_cnt_q <= 4'h1;
                                addr_q    <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                                state_q   <= ST_TX;
                            end
                            else
                            begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // eeslv_top

`default_nettype wire

// >>> tb/eeslv_bus_master.sv
// bus master model driving the serial clock and data line
`default_nettype none
module eeslv_bus_master
(
    // clock
    input  wire logic       core_clk,
    // bus lines
    input  wire logic       sda_i,
    output var  logic       scl_o,
    output var  logic       sda_low,
    // results for the bench
    output var  logic       res_v,
    output var  logic [7:0] res_d
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        scl_o   = 1'b1;
        sda_low = 1'b0;
        res_v   = 1'b0;
        res_d   = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // data moves only while the clock is low
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_low <= ~b;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        s = sda_i;
        scl_o <= 1'b0;
    endtask

    // start, also as repeated start
    task automatic start_c();
        tick(2);
        sda_low <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
    endtask

    // stop once the line was released
    task automatic stop_c();
        tick(2);
        sda_low <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask

    task automatic post(input logic [7:0] v, input logic p);
        if (p)
        begin
            res_d <= v;
            res_v <= 1'b1;
            tick(1);
            res_v <= 1'b0;
        end
    endtask

    // msb first, then released for the ack
    task automatic wr_byte(input logic [7:0] b, input logic p, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, a);
        post({7'h00, a}, p);
    endtask

    // low ack asks for one more byte
    task automatic rd_byte(input logic more);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~more, s);
        post(d, 1'b1);
    endtask
endmodule // eeslv_bus_master
`default_nettype wire

// >>> tb/eeslv_top_props.sv
// port assertions of the two-wire memory slave
`default_nettype none
module eeslv_top_props
#(
    parameter int WRITE_CYCLES = 125000
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // bus and status
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o_q,
    input wire logic sda_oe_q,
    input wire logic busy_q,
    input wire logic standby_q
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        scl_q;
    logic        sda_q;
    logic [3:0]  stop_age_q;
    logic [19:0] busy_cnt_q;

    // pin-level stop age and busy length
    always @(posedge core_clk)
    begin
        scl_q      <= scl_i;
        sda_q      <= sda_i;
        busy_cnt_q <= busy_q ? busy_cnt_q + 20'h1 : 20'h0;
        if (!reset_n)
            stop_age_q <= 4'hF;
        else if (scl_q && scl_i && !sda_q && sda_i)
            stop_age_q <= 4'h0;
        else if (stop_age_q != 4'hF)
            stop_age_q <= stop_age_q + 4'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_pin_stop;
        scl_q && scl_i && !sda_q && sda_i;
    endsequence
    sequence s_ack_hold;
        sda_oe_q [*6];
    endsequence

    a_drive_low_only: assert property (sda_oe_q |-> !sda_o_q)
        else $error("data line driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_q) |-> !scl_i)
        else $error("data drive changed while clock high");
    a_busy_no_drive: assert property (busy_q |-> !sda_oe_q)
        else $error("line driven while programming");
    a_busy_after_stop: assert property ($rose(busy_q) |-> stop_age_q inside {[4'h1:4'h8]})
        else $error("programming began without a stop");
    a_busy_length: assert property ($fell(busy_q) |->
        busy_cnt_q >= WRITE_CYCLES && busy_cnt_q <= WRITE_CYCLES + 8)
        else $error("programming time wrong");
    a_stop_standby: assert property (s_pin_stop |-> ##[1:8] standby_q)
        else $error("no standby after stop");
    a_ack_hold: assert property ($rose(sda_oe_q) |-> s_ack_hold)
        else $error("drive pulse too short");
    a_wake_on_ack: assert property ($fell(standby_q) |-> sda_oe_q || $past(sda_oe_q))
        else $error("left standby without an ack");
endmodule // eeslv_top_props

bind eeslv_top eeslv_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_props
(
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_o_q   (sda_o_q),
    .sda_oe_q  (sda_oe_q),
    .busy_q    (busy_q),
    .standby_q (standby_q)
);
`default_nettype wire

// >>> tb/eeslv_top_tb.sv
// self-checking bench of the two-wire memory slave
`default_nettype none
module eeslv_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WC = 400;
    logic       core_clk   = 1'b0;
    logic       reset_n    = 1'b0;
    logic       scl, m_low, res_v, sda, a;
    logic       sda_o_q, sda_oe_q, busy_q, standby_q;
    logic [7:0] res_d, base, wa, wd;
    logic [7:0] mem [0:255];
    logic [7:0] exp_q [$];
    int         n_errors   = 0;
    int         n_compared = 0;
    int         seed       = 59;

    always #20 core_clk = ~core_clk;
    // wired line with pull-up
    assign sda = ~((sda_oe_q & ~sda_o_q) | m_low);

    eeslv_top #(.WRITE_CYCLES(WC)) i_dut
    (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .scl_i     (scl),
        .sda_i     (sda),
        .sda_o_q   (sda_o_q),
        .sda_oe_q  (sda_oe_q),
        .busy_q    (busy_q),
        .standby_q (standby_q)
    );
    eeslv_bus_master i_mst
    (
        .core_clk (core_clk),
        .sda_i    (sda),
        .scl_o    (scl),
        .sda_low  (m_low),
        .res_v    (res_v),
        .res_d    (res_d)
    );

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // results taken oldest note first
    always @(posedge core_clk)
        if (res_v === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(res_d, 8'hXX, "result without note");
            else
                check(res_d, exp_q.pop_front(), "bus result");
        end

    task automatic wb(input logic [7:0] b, input logic [7:0] e);
        exp_q.push_back(e);
        i_mst.wr_byte(b, 1'b1, a);
    endtask
    task automatic rb(input logic [7:0] e, input logic more);
        exp_q.push_back(e);
        i_mst.rd_byte(more);
    endtask

    task automatic poll();
        int k;
        i_mst.start_c();
        wb(8'h60, 8'h01);
        for (k = 0; k < 30 && a !== 1'b0; k++)
        begin
            i_mst.start_c();
            i_mst.wr_byte(8'h60, 1'b0, a);
        end
        check({7'h00, a}, 8'h00, "poll ack");
        if (a !== 1'b0)
            print_verdict();
        i_mst.stop_c();
    endtask

    initial
    begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(negedge core_clk);
        check({5'h00, sda_oe_q, busy_q, standby_q}, 8'h01, "reset state");
        for (int t = 0; t < 16; t++)
        begin
            i_mst.start_c();
            wb({4'(t), 3'($random(seed)), 1'b0}, (t == 6) ? 8'h00 : 8'h01);
            i_mst.stop_c();
        end
        $display("test address match done");
        wa = 8'($random(seed));
        wd = 8'($random(seed));
        mem[wa] = wd;
        i_mst.start_c();
        wb(8'h60, 8'h00);
        wb(wa, 8'h00);
        wb(wd, 8'h00);
        i_mst.stop_c();
        i_mst.tick(4);
        @(negedge core_clk);
        check({7'h00, busy_q}, 8'h01, "busy after stop");
        poll();
        $display("test byte write done");
        base = 8'($random(seed)) & 8'hFC;
        i_mst.start_c();
        wb(8'h60, 8'h00);
        wb(base | 8'h02, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            wd = 8'($random(seed));
            mem[base | 8'((k + 2) % 4)] = wd;
            wb(wd, 8'h00);
        end
        i_mst.stop_c();
        poll();
        $display("test page write done");
        i_mst.start_c();
        wb(8'h61, 8'h00);
        for (int k = 0; k < 4; k++)
            rb(mem[base | 8'(k)], k < 3);
        i_mst.stop_c();
        $display("test current read done");
        i_mst.start_c();
        wb(8'h60, 8'h00);
        wb(wa, 8'h00);
        i_mst.start_c();
        wb(8'h61, 8'h00);
        rb(mem[wa], 1'b0);
        i_mst.stop_c();
        i_mst.tick(8);
        @(negedge core_clk);
        check({7'h00, standby_q}, 8'h01, "standby after read");
        $display("test random read done");
        for (int k = 0; k < 100 && exp_q.size() != 0; k++)
            @(posedge core_clk);
        check(8'(exp_q.size()), 8'h00, "notes left");
        print_verdict();
    end
endmodule // eeslv_top_tb
`default_nettype wire
